// ---- verilog/exec_pkg.sv ----
// constants, opcodes and types shared by the instruction execution block
package exec_pkg;

	// 14-bit instruction word opcodes (upper bits, whole word for return and halt)
	localparam logic [5:0] OP_FILE_MINUS_ACC = 6'h02;
	localparam logic [5:0] OP_FILE_XOR_ACC = 6'h06;
	localparam logic [5:0] OP_ROTATE_RIGHT = 6'h0C;
	localparam logic [5:0] OP_NIBBLE_EXCHANGE = 6'h0E;
	localparam logic [4:0] OP_LITERAL_MINUS_ACC = 5'h1E;
	localparam logic [5:0] OP_LITERAL_XOR_ACC = 6'h3A;
	localparam logic [13:0] OP_RETURN = 14'h0008;
	localparam logic [13:0] OP_HALT = 14'h0063;

	// instruction field positions
	localparam int DEST_BIT = 7;
	localparam int FILE_ADDR_MSB = 6;
	localparam int LIT_MSB = 7;

	// status bit positions in the status byte
	localparam int CARRY_POS = 0;
	localparam int HALF_CARRY_POS = 1;
	localparam int ZERO_POS = 2;
	localparam int POWER_DOWN_POS = 3;
	localparam int WATCHDOG_EXPIRY_POS = 4;

	// values after reset
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h18;
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [7:0] WATCHDOG_CLEAR = 8'h00;

	// cycle counts and stack depth
	localparam logic [1:0] RETURN_CYCLES = 2'h2;
	localparam int STACK_DEPTH = 8;

	// execution sequencer states
	typedef enum logic [1:0]
	{
		ST_RUN = 2'b00,
		ST_RETURN_WAIT = 2'b01,
		ST_SLEEP = 2'b10
	} exec_state_e;

	// instruction classes
	typedef enum logic [2:0]
	{
		CL_NONE = 3'b000,
		CL_SUB = 3'b001,
		CL_XOR = 3'b010,
		CL_ROTATE = 3'b011,
		CL_SWAP = 3'b100
	} alu_class_e;

endpackage

// ---- verilog/exec_alu.sv ----
// combinational arithmetic for subtract, xor, rotate and nibble exchange
`timescale 1ns/1ps

module exec_alu
(
	input wire exec_pkg::alu_class_e op,
	input wire logic [7:0] a,
	input wire logic [7:0] acc,
	input wire logic carry_in,
	output logic [7:0] result,
	output logic carry_out,
	output logic half_carry_out
);

	logic [8:0] diff;
	logic [4:0] low_diff;

	// a minus acc; carry set when no borrow
	always_comb
	begin
		diff = {1'b0, a} + {1'b0, ~acc} + 9'h001;
		low_diff = {1'b0, a[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
		result = a;
		carry_out = carry_in;
		half_carry_out = 1'b0;
		unique case (op)
			exec_pkg::CL_SUB:
			begin
				result = diff[7:0];
				carry_out = diff[8];
				half_carry_out = low_diff[4];
			end
			exec_pkg::CL_XOR:
				result = a ^ acc;
			exec_pkg::CL_ROTATE:
			begin
				result = {carry_in, a[7:1]};
				carry_out = a[0];
			end
			exec_pkg::CL_SWAP:
				result = {a[3:0], a[7:4]};
			exec_pkg::CL_NONE:
				result = a;
		endcase
	end

endmodule

// ---- verilog/return_stack.sv ----
// eight entry circular hardware return stack
`timescale 1ns/1ps

module return_stack
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic push,
	input wire logic [12:0] push_addr,
	input wire logic pop,
	output logic [12:0] head
);

	typedef struct packed
	{
		logic [exec_pkg::STACK_DEPTH-1:0][12:0] entry;
		logic [2:0] ptr;
	} stack_s;

	stack_s cur;
	stack_s next_cur;

	// push writes above the head, pop steps the pointer back
	always_comb
	begin
		next_cur = cur;
		if (push)
		begin
			next_cur.entry[cur.ptr + 3'h1] = push_addr;
			next_cur.ptr = cur.ptr + 3'h1;
		end
		else if (pop)
			next_cur.ptr = cur.ptr - 3'h1;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign head = cur.entry[cur.ptr];

endmodule

// ---- verilog/exec_core.sv ----
// execution of the halt, return, subtract, rotate, swap and xor instructions
// Function
// - halt clears watchdog, sets expiry, clears power-down
// - after halt, sleep with oscillator stopped
// - return pops stack into PC, two cycles
// - literal minus acc into acc, flags C DC Z
// - rotate right through carry, only carry
// - destination bit 0 acc, 1 file
// - file minus acc to destination, C DC Z
// - swap nibbles to destination, no flags
// - literal xor acc into acc, zero only
// - file xor acc to destination, zero only
`timescale 1ns/1ps

module exec_core
(
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic INSTR_VALID,
	input wire logic [13:0] INSTR,
	input wire logic [7:0] FILE_RDATA,
	input wire logic CALL_PUSH,
	input wire logic [12:0] CALL_RETURN_ADDR,
	input wire logic WAKE,
	output logic [6:0] FILE_ADDR,
	output logic FILE_WE,
	output logic [7:0] FILE_WDATA,
	output logic [7:0] ACC,
	output logic CARRY_FLAG,
	output logic HALF_CARRY_FLAG,
	output logic ZERO_FLAG,
	output logic POWER_DOWN_FLAG,
	output logic WATCHDOG_EXPIRY_FLAG,
	output logic WATCHDOG_CLEAR,
	output logic OSC_STOP,
	output logic PC_LOAD,
	output logic [12:0] PC_VALUE,
	output logic BUSY
);

	////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed
	{
		exec_pkg::exec_state_e state;
		logic [1:0] cycle;
		logic [7:0] acc;
		logic [7:0] status;
		logic [6:0] faddr;
		logic fwe;
		logic [7:0] fwdata;
		logic wdt_clear;
		logic pc_load;
		logic [12:0] pc_value;
		logic wake_s1;
		logic wake_s2;
	} core_s;

	core_s cur;
	core_s next_cur;

	exec_pkg::alu_class_e alu_op;
	logic [7:0] alu_a;
	logic [7:0] alu_result;
	logic alu_carry;
	logic alu_half;
	logic [12:0] stack_head;
	logic stack_pop;
	logic [5:0] op6;
	logic is_file_op;
	logic dest_file;
	logic set_cdz;
	logic set_z;
	logic set_c;

	////////////////////////////////////////////////////////////////////
	// decode

	// classify the instruction word
	always_comb
	begin
		op6 = INSTR[13:8];
		alu_op = exec_pkg::CL_NONE;
		is_file_op = 1'b0;
		set_cdz = 1'b0;
		set_z = 1'b0;
		set_c = 1'b0;
		alu_a = FILE_RDATA;
		if (op6 == exec_pkg::OP_FILE_MINUS_ACC)
		begin
			alu_op = exec_pkg::CL_SUB;
			is_file_op = 1'b1;
			set_cdz = 1'b1;
		end
		else if (op6 == exec_pkg::OP_FILE_XOR_ACC)
		begin
			alu_op = exec_pkg::CL_XOR;
			is_file_op = 1'b1;
			set_z = 1'b1;
		end
		else if (op6 == exec_pkg::OP_ROTATE_RIGHT)
		begin
			alu_op = exec_pkg::CL_ROTATE;
			is_file_op = 1'b1;
			set_c = 1'b1;
		end
		else if (op6 == exec_pkg::OP_NIBBLE_EXCHANGE)
		begin
			alu_op = exec_pkg::CL_SWAP;
			is_file_op = 1'b1;
		end
		else if (INSTR[13:9] == exec_pkg::OP_LITERAL_MINUS_ACC)
		begin
			alu_op = exec_pkg::CL_SUB;
			alu_a = INSTR[exec_pkg::LIT_MSB:0];
			set_cdz = 1'b1;
		end
		else if (op6 == exec_pkg::OP_LITERAL_XOR_ACC)
		begin
			alu_op = exec_pkg::CL_XOR;
			alu_a = INSTR[exec_pkg::LIT_MSB:0];
			set_z = 1'b1;
		end
		dest_file = is_file_op & INSTR[exec_pkg::DEST_BIT];
	end

	// file register address always follows the instruction
	assign FILE_ADDR = INSTR[exec_pkg::FILE_ADDR_MSB:0];

	////////////////////////////////////////////////////////////////////
	// datapath helpers

	exec_alu alu
	(
		.op(alu_op),
		.a(alu_a),
		.acc(cur.acc),
		.carry_in(cur.status[exec_pkg::CARRY_POS]),
		.result(alu_result),
		.carry_out(alu_carry),
		.half_carry_out(alu_half)
	);

	return_stack stack
	(
		.clk(SYS_CLK),
		.arst_n(ARST_N),
		.push(CALL_PUSH),
		.push_addr(CALL_RETURN_ADDR),
		.pop(stack_pop),
		.head(stack_head)
	);

	////////////////////////////////////////////////////////////////////
	// sequencer

	// one instruction per cycle, return holds for a second cycle
	always_comb
	begin
		next_cur = cur;
		next_cur.fwe = 1'b0;
		next_cur.wdt_clear = 1'b0;
		next_cur.pc_load = 1'b0;
		next_cur.wake_s1 = WAKE;
		next_cur.wake_s2 = cur.wake_s1;
		stack_pop = 1'b0;
		unique case (cur.state)
			exec_pkg::ST_RUN:
			begin
				if (INSTR_VALID && INSTR == exec_pkg::OP_HALT)
				begin
					next_cur.wdt_clear = 1'b1;
					next_cur.status[exec_pkg::WATCHDOG_EXPIRY_POS] = 1'b1;
					next_cur.status[exec_pkg::POWER_DOWN_POS] = 1'b0;
					next_cur.state = exec_pkg::ST_SLEEP;
				end
				else if (INSTR_VALID && INSTR == exec_pkg::OP_RETURN)
				begin
					stack_pop = 1'b1;
					next_cur.pc_value = stack_head;
					next_cur.pc_load = 1'b1;
					next_cur.cycle = 2'h1;
					next_cur.state = exec_pkg::ST_RETURN_WAIT;
				end
				else if (INSTR_VALID && alu_op != exec_pkg::CL_NONE)
				begin
					if (dest_file)
					begin
						next_cur.fwe = 1'b1;
						next_cur.faddr = INSTR[exec_pkg::FILE_ADDR_MSB:0];
						next_cur.fwdata = alu_result;
					end
					else
						next_cur.acc = alu_result;
					if (set_cdz || set_c)
						next_cur.status[exec_pkg::CARRY_POS] = alu_carry;
					if (set_cdz)
						next_cur.status[exec_pkg::HALF_CARRY_POS] = alu_half;
					if (set_cdz || set_z)
						next_cur.status[exec_pkg::ZERO_POS] = (alu_result == 8'h00);
				end
			end
			exec_pkg::ST_RETURN_WAIT:
			begin
				// second cycle of return: a dead cycle, no flags touched
				next_cur.cycle = cur.cycle + 2'h1;
				if (cur.cycle + 2'h1 >= exec_pkg::RETURN_CYCLES)
				begin
					next_cur.cycle = 2'h0;
					next_cur.state = exec_pkg::ST_RUN;
				end
			end
			exec_pkg::ST_SLEEP:
			begin
				// oscillator stopped; only a wake event resumes
				if (cur.wake_s2)
					next_cur.state = exec_pkg::ST_RUN;
			end
			default:
				next_cur.state = exec_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			cur <= '0;
			cur.acc <= exec_pkg::ACC_RESET;
			cur.status <= exec_pkg::STATUS_RESET;
			cur.pc_value <= exec_pkg::PC_RESET;
			cur.state <= exec_pkg::ST_RUN;
		end
		else
			cur <= next_cur;
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	assign FILE_WE = cur.fwe;
	assign FILE_WDATA = cur.fwdata;
	assign ACC = cur.acc;
	assign CARRY_FLAG = cur.status[exec_pkg::CARRY_POS];
	assign HALF_CARRY_FLAG = cur.status[exec_pkg::HALF_CARRY_POS];
	assign ZERO_FLAG = cur.status[exec_pkg::ZERO_POS];
	assign POWER_DOWN_FLAG = cur.status[exec_pkg::POWER_DOWN_POS];
	assign WATCHDOG_EXPIRY_FLAG = cur.status[exec_pkg::WATCHDOG_EXPIRY_POS];
	assign WATCHDOG_CLEAR = cur.wdt_clear;
	assign OSC_STOP = (cur.state == exec_pkg::ST_SLEEP);
	assign PC_LOAD = cur.pc_load;
	assign PC_VALUE = cur.pc_value;
	assign BUSY = (cur.state != exec_pkg::ST_RUN);

endmodule

// ---- test/exec_checker.sv ----
// assertions on the ports of the instruction execution block
`timescale 1ns/1ps

module exec_checker
(
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic INSTR_VALID,
	input wire logic [13:0] INSTR,
	input wire logic [7:0] FILE_RDATA,
	input wire logic FILE_WE,
	input wire logic [7:0] FILE_WDATA,
	input wire logic [7:0] ACC,
	input wire logic CARRY_FLAG,
	input wire logic HALF_CARRY_FLAG,
	input wire logic ZERO_FLAG,
	input wire logic POWER_DOWN_FLAG,
	input wire logic WATCHDOG_EXPIRY_FLAG,
	input wire logic WATCHDOG_CLEAR,
	input wire logic OSC_STOP,
	input wire logic PC_LOAD,
	input wire logic BUSY
);

////////////////////////////////////////////////////////////////////////////
// taken instruction and its fields
logic tk;
logic fop;
logic [5:0] op;
logic [7:0] lit;
logic [2:0] flg;
assign tk = INSTR_VALID && !BUSY;
assign op = INSTR[13:8];
assign lit = INSTR[7:0];
assign flg = {CARRY_FLAG, HALF_CARRY_FLAG, ZERO_FLAG};
assign fop = op == exec_pkg::OP_FILE_MINUS_ACC
	|| op == exec_pkg::OP_FILE_XOR_ACC
	|| op == exec_pkg::OP_ROTATE_RIGHT
	|| op == exec_pkg::OP_NIBBLE_EXCHANGE;

default clocking @(posedge SYS_CLK); endclocking
default disable iff (!ARST_N);

////////////////////////////////////////////////////////////////////////////
// properties
halt_clear_a: assert property (
	tk && INSTR == exec_pkg::OP_HALT |=> WATCHDOG_CLEAR
	&& !POWER_DOWN_FLAG && WATCHDOG_EXPIRY_FLAG)
	else $error("halt status wrong");
halt_sleep_a: assert property (
	tk && INSTR == exec_pkg::OP_HALT |=> (OSC_STOP && BUSY && !FILE_WE)[*2])
	else $error("sleep not entered");
return_load_a: assert property (
	tk && INSTR == exec_pkg::OP_RETURN |=> PC_LOAD && BUSY ##1 !BUSY)
	else $error("return timing wrong");
return_flags_a: assert property (
	tk && INSTR == exec_pkg::OP_RETURN |=> flg == $past(flg))
	else $error("return changed flags");
lit_sub_a: assert property (
	tk && INSTR[13:9] == exec_pkg::OP_LITERAL_MINUS_ACC
	|=> (ACC + $past(ACC)) == $past(lit)
	&& CARRY_FLAG == ($past(lit) >= $past(ACC)))
	else $error("literal subtract wrong");
rotate_acc_a: assert property (
	tk && op == exec_pkg::OP_ROTATE_RIGHT && !INSTR[7]
	|=> ACC == (({$past(CARRY_FLAG), 8'h00} | $past(FILE_RDATA)) >> 1)
	&& CARRY_FLAG == $past(FILE_RDATA[0]) && ZERO_FLAG == $past(ZERO_FLAG))
	else $error("rotate wrong");
dest_select_a: assert property (
	tk && fop |=> FILE_WE == $past(INSTR[7]))
	else $error("destination wrong");
swap_file_a: assert property (
	tk && op == exec_pkg::OP_NIBBLE_EXCHANGE && INSTR[7]
	|=> FILE_WDATA == {$past(FILE_RDATA[3:0]), $past(FILE_RDATA[7:4])}
	&& flg == $past(flg))
	else $error("nibble exchange wrong");
lit_xor_a: assert property (
	tk && op == exec_pkg::OP_LITERAL_XOR_ACC
	|=> ACC == ($past(ACC) ^ $past(lit)) && ZERO_FLAG == (ACC == 8'h00)
	&& CARRY_FLAG == $past(CARRY_FLAG))
	else $error("literal xor wrong");

// main scenarios
cover property (tk && INSTR == exec_pkg::OP_HALT);
cover property (tk && INSTR == exec_pkg::OP_RETURN);
cover property (FILE_WE);

endmodule

bind exec_core exec_checker chk (.SYS_CLK, .ARST_N, .INSTR_VALID, .INSTR,
	.FILE_RDATA, .FILE_WE, .FILE_WDATA, .ACC, .CARRY_FLAG, .HALF_CARRY_FLAG,
	.ZERO_FLAG, .POWER_DOWN_FLAG, .WATCHDOG_EXPIRY_FLAG, .WATCHDOG_CLEAR,
	.OSC_STOP, .PC_LOAD, .BUSY);

// ---- test/tb.sv ----
// self-checking bench for the instruction execution block
`timescale 1ns/1ps

module tb;

logic SYS_CLK = 1'h0;
logic ARST_N = 1'h0;
logic INSTR_VALID = 1'h0;
logic CALL_PUSH = 1'h0;
logic WAKE = 1'h0;
logic [13:0] INSTR = 14'h0000;
logic [7:0] FILE_RDATA = 8'h00;
logic [12:0] CALL_RETURN_ADDR = 13'h0000;
logic [6:0] FILE_ADDR;
logic [7:0] FILE_WDATA, ACC;
logic [12:0] PC_VALUE;
logic FILE_WE, CARRY_FLAG, HALF_CARRY_FLAG, ZERO_FLAG, POWER_DOWN_FLAG;
logic WATCHDOG_EXPIRY_FLAG, WATCHDOG_CLEAR, OSC_STOP, PC_LOAD, BUSY;
logic [2:0] flg;
int n_errors = 0;
int check_count = 0;
int cyc = 0;

assign flg = {CARRY_FLAG, HALF_CARRY_FLAG, ZERO_FLAG};

exec_core uut (.*);

// clock and hang guard
initial forever #5 SYS_CLK = ~SYS_CLK;
always @(posedge SYS_CLK)
begin
	cyc++;
	if (cyc == 1000)
	begin
		n_errors++;
		end_of_test();
	end
end

////////////////////////////////////////////////////////////////////////////
// comparison, instruction and closing tasks
task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
	check_count++;
	if (seen !== exp)
	begin
		n_errors++;
		$display("ERROR %0t seen %h expected %h", $time, seen, exp);
	end
endtask

task automatic op(input logic [13:0] i, input logic [7:0] rd);
	@(posedge SYS_CLK);
	INSTR_VALID <= 1'h1;
	INSTR <= i;
	FILE_RDATA <= rd;
	@(posedge SYS_CLK);
	INSTR_VALID <= 1'h0;
	#1;
endtask

task end_of_test;
	$display("errors %0d checks %0d", n_errors, check_count);
	if (n_errors == 0 && check_count > 0)
		$display("TEST PASSED");
	else
		$display("TEST FAILED");
	$finish;
endtask

////////////////////////////////////////////////////////////////////////////
// main sequence
initial
begin
	repeat (3) @(posedge SYS_CLK);
	ARST_N <= 1'h1;
	op(14'h3A5A, 8'h00);
	chk(ACC, 8'h5A);
	op(14'h3A5A, 8'h00);
	chk(flg, 3'h1);
	op(14'h3C05, 8'h00);
	chk(ACC, 8'h05);
	chk(flg, 3'h6);
	op(14'h3C00, 8'h00);
	chk(ACC, 8'hFB);
	chk(flg, 3'h0);
	op(14'h0285, 8'hFB);
	chk(FILE_WE, 1'h1);
	chk(FILE_WDATA, 8'h00);
	chk(flg, 3'h7);
	op(14'h0C05, 8'h80);
	chk(FILE_WE, 1'h0);
	chk(ACC, 8'hC0);
	chk(flg, 3'h3);
	op(14'h0E85, 8'h3C);
	chk(FILE_WDATA, 8'hC3);
	chk(flg, 3'h3);
	op(14'h0605, 8'hC1);
	chk(ACC, 8'h01);
	chk(FILE_ADDR, 7'h05);
	chk(flg, 3'h2);
	@(posedge SYS_CLK);
	CALL_PUSH <= 1'h1;
	CALL_RETURN_ADDR <= 13'h0ABC;
	@(posedge SYS_CLK);
	CALL_PUSH <= 1'h0;
	op(14'h0008, 8'h00);
	chk({PC_LOAD, BUSY}, 2'h3);
	chk(PC_VALUE, 13'h0ABC);
	chk(flg, 3'h2);
	op(14'h0063, 8'h00);
	chk(WATCHDOG_CLEAR, 1'h1);
	chk({POWER_DOWN_FLAG, WATCHDOG_EXPIRY_FLAG}, 2'h1);
	op(14'h3AFF, 8'h00);
	chk({OSC_STOP, ACC}, 9'h101);
	chk(WATCHDOG_CLEAR, 1'h0);
	@(posedge SYS_CLK);
	WAKE <= 1'h1;
	repeat (5) @(posedge SYS_CLK);
	WAKE <= 1'h0;
	#1;
	chk(OSC_STOP, 1'h0);
	end_of_test();
end

endmodule
